// >>> src/nmio_dev.sv
/*
 * Interface end: joins a nibble-bus processor to byte-wide program
 * memory and one four-bit port. Builds the memory address, returns
 * instructions, holds the port select operand and drives the strobes.
 * Assumes the processor end shares clk_sys_i and ce_i, one enabled
 * clock per cycle state, and that memory inputs are valid in fetch states.
 */
`include "nmio_defines.svh"

// Operation
// - Build 4K address from three address-state nibbles
// - Return instruction as two nibbles, fetch states
// - Keep port select operand, serve port transfers
// - Memory gives high nibble upper, low lower
// - Half-select clear input clears only that flop
// - Read strobe on port or memory read
// - Write strobe on port or memory write
// - Access strobe only on memory read/write
// - Half-select high picks high-order nibble
// - Address outputs hold first two address nibbles, select operand after X1
// - Bank selects: third nibble or operand upper
// - Command qualifier gates select and I/O
// - Cycle states follow processor sync
// - Drivers release bus after second fetch/execute
// - All exchange over one four-bit bus
// - One bidirectional port, also memory write data
// - Timing derives from system-supplied clocking
// - Nibbles map to low, middle, bank outputs
// - Store operand, upper to banks each execute-one except memory instructions
// - Memory instructions force bank selects all ones
// - Half-select toggles after each memory operation
module nmio_dev
    import nmio_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic ce_i,
    input wire logic half_sel_clr_i,
    // Link
    nmio_if.dev link,
    // Program memory
    input wire logic [3:0] upper_nibble_in_i,
    input wire logic [3:0] lower_nibble_in_i,
    output logic [7:0] mem_addr_out_o,
    output logic [3:0] bank_select_out_o,
    output logic progmem_access_strobe_n_o,
    output logic half_sel_o,
    // Port
    input wire logic [3:0] port_nibble_pins_i,
    output logic [3:0] port_nibble_pins_o,
    output logic port_nibble_pins_oe_o,
    output logic port_rd_n_o,
    output logic port_wr_n_o
);

    nmio_state_t st_q;
    logic live_q;
    logic fetch_q;
    logic exec_q;
    logic [3:0] opr_q;
    logic [3:0] opa_q;
    logic [7:0] src_q;
    logic [3:0] rdat_q;
    logic [3:0] port_q;
    logic hs_q;

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    wire [3:0] bus = link.cpu_nibble_bus;
    wire in_a1 = live_q && st_q == ST_A1;
    wire in_a2 = live_q && st_q == ST_A2;
    wire in_a3 = live_q && st_q == ST_A3;
    wire in_x2 = live_q && st_q == ST_X2;
    wire in_x3 = live_q && st_q == ST_X3;
    wire is_sel = opr_q == `NMIO_OPR_SEL && opa_q[0];
    wire is_io = opr_q == `NMIO_OPR_IO;
    wire is_pwr = is_io && opa_q == `NMIO_OPA_PWR;
    wire is_mwr = is_io && opa_q == `NMIO_OPA_MWR;
    wire is_prd = is_io && opa_q == `NMIO_OPA_PRD;
    wire is_mrd = is_io && opa_q == `NMIO_OPA_MRD;
    wire is_pm = is_mwr || is_mrd;
    // Unqualified traffic is ignored: execution needs the qualifier at X1
    wire act_x1 = live_q && st_q == ST_X1 && link.cmd_qual;
    wire io_now = act_x1 || (exec_q && (in_x2 || in_x3));
    wire [3:0] mem_nib = hs_q ? upper_nibble_in_i : lower_nibble_in_i;

    // ----------------------------------------------------------------
    // Strobes and port drive
    // ----------------------------------------------------------------
    assign port_rd_n_o = !(io_now && (is_prd || is_mrd));
    assign port_wr_n_o = !(io_now && (is_pwr || is_mwr));
    assign progmem_access_strobe_n_o = !(io_now && is_pm);
    assign half_sel_o = hs_q;
    assign port_nibble_pins_o = port_q;
    assign port_nibble_pins_oe_o = exec_q && in_x3 && (is_pwr || is_mwr);

    // ----------------------------------------------------------------
    // Nibble bus drive: memory data comes straight through in fetch
    // states, since address settles only at the end of the third state
    // ----------------------------------------------------------------
    wire drv_m = fetch_q && (st_q == ST_M1 || st_q == ST_M2);
    wire drv_x = exec_q && in_x2 && (is_prd || is_mrd);
    // Released by the next state; the processor drives again after that
    assign link.dev_d_oe = drv_m || drv_x;
    assign link.dev_d = drv_x ? rdat_q :
                        st_q == ST_M1 ? upper_nibble_in_i : lower_nibble_in_i;

    // ----------------------------------------------------------------
    // Cycle sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            st_q <= ST_X3;
            live_q <= 1'b0;
        end
        else if (ce_i)
        begin
            st_q <= link.sync ? ST_A1 : nmio_next(st_q);
            live_q <= live_q || link.sync;
        end
    end

    // ----------------------------------------------------------------
    // Address and bank outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            mem_addr_out_o <= `NMIO_ADDR_ZERO;
            bank_select_out_o <= `NMIO_NIB_ZERO;
            fetch_q <= 1'b0;
        end
        else if (ce_i)
        begin
            if (in_a1)
                mem_addr_out_o[3:0] <= bus;
            if (in_a2)
                mem_addr_out_o[7:4] <= bus;
            if (in_a3)
            begin
                bank_select_out_o <= bus;
                fetch_q <= link.cmd_qual;
            end
            if (st_q == ST_M2)
                fetch_q <= 1'b0;
            if (live_q && st_q == ST_X1)
            begin
                mem_addr_out_o <= src_q;
                bank_select_out_o <= (act_x1 && is_pm) ? `NMIO_NIB_ONES : src_q[7:4];
            end
        end
    end

    // ----------------------------------------------------------------
    // Instruction, operand and data capture
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            opr_q <= `NMIO_NIB_ZERO;
            opa_q <= `NMIO_NIB_ZERO;
            exec_q <= 1'b0;
            src_q <= `NMIO_ADDR_ZERO;
            rdat_q <= `NMIO_NIB_ZERO;
            port_q <= `NMIO_NIB_ZERO;
        end
        else if (ce_i)
        begin
            // Foreign fetches leave a no-op so nothing decodes
            if (st_q == ST_M1)
                opr_q <= fetch_q ? upper_nibble_in_i : `NMIO_NIB_ZERO;
            if (st_q == ST_M2)
                opa_q <= fetch_q ? lower_nibble_in_i : `NMIO_NIB_ZERO;
            if (live_q && st_q == ST_X1)
            begin
                exec_q <= link.cmd_qual;
                rdat_q <= is_mrd ? mem_nib : port_nibble_pins_i;
            end
            if (in_x3)
                exec_q <= 1'b0;
            if (exec_q && in_x2 && is_sel)
                src_q[7:4] <= bus;
            if (exec_q && in_x3 && is_sel)
                src_q[3:0] <= bus;
            if (exec_q && in_x2 && (is_pwr || is_mwr))
                port_q <= bus;
        end
    end

    // ----------------------------------------------------------------
    // Half-select flop: own clear input, system reset only for defined state
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_i or posedge reset_i)
    begin
        if (reset_i)
            hs_q <= 1'b0;
        else if (ce_i)
        begin
            if (half_sel_clr_i)
                hs_q <= 1'b0;
            else if (exec_q && in_x3 && is_pm)
                hs_q <= !hs_q;
        end
    end

endmodule

// >>> src/nmio_defines.svh
/*
 * Shared constants for the nibble-bus memory and port interface.
 * Assumes it is included by bare name from package and design files.
 */
`ifndef NMIO_DEFINES_SVH
`define NMIO_DEFINES_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define NMIO_NIB_W 4
`define NMIO_ADDR_W 8
`define NMIO_PC_W 12

// ----------------------------------------------------------------
// Instruction codes (upper nibble, lower nibble)
// ----------------------------------------------------------------
`define NMIO_OPR_SEL 4'h2
`define NMIO_OPR_IO 4'he
`define NMIO_OPA_PWR 4'h2
`define NMIO_OPA_MWR 4'h3
`define NMIO_OPA_MRD 4'h9
`define NMIO_OPA_PRD 4'ha

// ----------------------------------------------------------------
// Reset and forced values
// ----------------------------------------------------------------
`define NMIO_NIB_ZERO 4'h0
`define NMIO_NIB_ONES 4'hf
`define NMIO_ADDR_ZERO 8'h00
`define NMIO_PC_ZERO 12'h000
`define NMIO_BUS_IDLE 4'hf

`endif

// >>> src/nmio_pkg.sv
/*
 * Types for the nibble-bus memory and port interface.
 * Assumes nmio_defines.svh is on the include path.
 */
`include "nmio_defines.svh"

package nmio_pkg;

    // ----------------------------------------------------------------
    // Instruction cycle states, Gray coded along the cycle
    // ----------------------------------------------------------------
    typedef enum logic [2:0]
    {
        ST_A1 = 3'b000,
        ST_A2 = 3'b001,
        ST_A3 = 3'b011,
        ST_M1 = 3'b010,
        ST_M2 = 3'b110,
        ST_X1 = 3'b111,
        ST_X2 = 3'b101,
        ST_X3 = 3'b100
    } nmio_state_t;

    function automatic nmio_state_t nmio_next(input nmio_state_t s);
        nmio_state_t n;
        n = ST_A1;
        case (s)
            ST_A1: n = ST_A2;
            ST_A2: n = ST_A3;
            ST_A3: n = ST_M1;
            ST_M1: n = ST_M2;
            ST_M2: n = ST_X1;
            ST_X1: n = ST_X2;
            ST_X2: n = ST_X3;
            ST_X3: n = ST_A1;
            default: n = ST_A1;
        endcase
        return n;
    endfunction

endpackage

// >>> src/nmio_if.sv
/*
 * Nibble bus between the processor end and the interface end.
 * Assumes each end drives its own data and enable; the bus level is
 * resolved here, and an undriven bus reads all ones.
 */
`include "nmio_defines.svh"

interface nmio_if;

    logic [3:0] cpu_d;
    logic cpu_d_oe;
    logic [3:0] dev_d;
    logic dev_d_oe;
    logic sync;
    logic cmd_qual;
    wire logic [3:0] cpu_nibble_bus;

    // ----------------------------------------------------------------
    // Bus resolution
    // ----------------------------------------------------------------
    assign cpu_nibble_bus = dev_d_oe ? dev_d : (cpu_d_oe ? cpu_d : `NMIO_BUS_IDLE);

    modport dev
    (
        input cpu_nibble_bus,
        input sync,
        input cmd_qual,
        output dev_d,
        output dev_d_oe
    );

    modport cpu
    (
        input cpu_nibble_bus,
        output cpu_d,
        output cpu_d_oe,
        output sync,
        output cmd_qual
    );

endinterface

// >>> src/nmio_cpu.sv
/*
 * Processor end of the nibble bus: runs the eight-state cycle, sends
 * the program address, fetches instructions and executes port and
 * memory transfers.
 * Assumes the interface end sits on the same clock and clock enable.
 */
`include "nmio_defines.svh"

module nmio_cpu
    import nmio_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic ce_i,
    // Link
    nmio_if.cpu link,
    // User side
    input wire logic [11:0] pc_i,
    input wire logic fetch_cmd_i,
    input wire logic [3:0] acc_i,
    input wire logic [7:0] src_addr_i,
    output logic [7:0] instr_o,
    output logic instr_valid_o,
    output logic [3:0] rd_data_o,
    output logic rd_valid_o
);

    nmio_state_t st_q;
    logic [11:0] pc_q;
    logic [3:0] acc_q;
    logic [7:0] src_q;
    logic [7:0] ins_q;

    // ----------------------------------------------------------------
    // Decode of the fetched instruction
    // ----------------------------------------------------------------
    wire is_sel = (ins_q[7:4] == `NMIO_OPR_SEL) && ins_q[0];
    wire is_io = ins_q[7:4] == `NMIO_OPR_IO;
    wire is_wr = is_io && (ins_q[3:0] == `NMIO_OPA_PWR || ins_q[3:0] == `NMIO_OPA_MWR);
    wire is_rd = is_io && (ins_q[3:0] == `NMIO_OPA_PRD || ins_q[3:0] == `NMIO_OPA_MRD);

    // ----------------------------------------------------------------
    // Bus drive: all traffic shares the one nibble bus
    // ----------------------------------------------------------------
    wire drv_a = st_q == ST_A1 || st_q == ST_A2 || st_q == ST_A3;
    wire drv_x2 = st_q == ST_X2 && (is_sel || is_wr);
    wire drv_x3 = st_q == ST_X3 && is_sel;

    assign link.cpu_d_oe = drv_a || drv_x2 || drv_x3;
    assign link.cpu_d = st_q == ST_A1 ? pc_q[3:0] :
                        st_q == ST_A2 ? pc_q[7:4] :
                        st_q == ST_A3 ? pc_q[11:8] :
                        drv_x3 ? src_q[3:0] :
                        is_sel ? src_q[7:4] : acc_q;

    // Sync marks the last state so both ends restart at the first address state
    assign link.sync = st_q == ST_X3;
    assign link.cmd_qual = (st_q == ST_A3 && fetch_cmd_i) ||
                           (st_q == ST_X1 && (is_sel || is_io));

    // ----------------------------------------------------------------
    // Sequencer and operand capture
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            st_q <= ST_X3;
            pc_q <= `NMIO_PC_ZERO;
            acc_q <= `NMIO_NIB_ZERO;
            src_q <= `NMIO_ADDR_ZERO;
        end
        else if (ce_i)
        begin
            st_q <= nmio_next(st_q);
            if (st_q == ST_X3)
            begin
                pc_q <= pc_i;
                acc_q <= acc_i;
                src_q <= src_addr_i;
            end
        end
    end

    // ----------------------------------------------------------------
    // Instruction and read data capture
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            ins_q <= `NMIO_ADDR_ZERO;
            instr_o <= `NMIO_ADDR_ZERO;
            instr_valid_o <= 1'b0;
            rd_data_o <= `NMIO_NIB_ZERO;
            rd_valid_o <= 1'b0;
        end
        else if (ce_i)
        begin
            instr_valid_o <= st_q == ST_M2;
            rd_valid_o <= st_q == ST_X2 && is_rd;
            if (st_q == ST_M1)
                ins_q[7:4] <= link.cpu_nibble_bus;
            if (st_q == ST_M2)
            begin
                ins_q[3:0] <= link.cpu_nibble_bus;
                instr_o <= {ins_q[7:4], link.cpu_nibble_bus};
            end
            if (st_q == ST_X2 && is_rd)
                rd_data_o <= link.cpu_nibble_bus;
        end
    end

endmodule

// >>> test/nmio_monitor.sv
/*
 * Checker on the nibble bus between the processor end and the interface end.
 * Assumes one enabled clock per cycle state on the shared clk_sys_i.
 */
module nmio_monitor
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_i,
    // Link
    input wire logic cpu_d_oe,
    input wire logic dev_d_oe,
    input wire logic sync,
    input wire logic cmd_qual
);
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------------------------------
    // Bus ownership and cycle timing
    // ----------------------------------------------------------------
    default clocking @(posedge clk_sys_i);
    endclocking
    default disable iff (reset_i);

    a_sync_period: assert property (sync |=> (!sync)[*7] ##1 sync)
        else $error("sync not once in eight states");
    a_one_driver: assert property (!(cpu_d_oe && dev_d_oe))
        else $error("both ends drive the bus");
    a_addr_states: assert property (sync |=> cpu_d_oe[*3] ##1 !cpu_d_oe)
        else $error("address states not driven by processor");
    a_fetch_answer: assert property (sync ##3 cmd_qual |=> dev_d_oe[*2] ##1 !dev_d_oe)
        else $error("fetch not answered in both fetch states");
    a_fetch_refused: assert property (sync ##3 !cmd_qual |=> (!dev_d_oe)[*2])
        else $error("unqualified fetch answered");
    a_exec_refused: assert property (sync ##6 !cmd_qual |=> !dev_d_oe)
        else $error("unqualified execute drives bus");
    a_exec_release: assert property (sync ##7 dev_d_oe |=> !dev_d_oe)
        else $error("bus not released after second execute state");
    a_dev_quiet: assert property (sync |-> (!dev_d_oe)[*4] ##3 !dev_d_oe ##2 !dev_d_oe)
        else $error("interface end drives bus in a processor state");
    a_cmd_states: assert property (cmd_qual |-> $past(sync, 3) || $past(sync, 6))
        else $error("command qualifier outside third address or first execute");

    c_fetch: cover property (sync ##3 cmd_qual ##1 dev_d_oe);
    c_refused: cover property (sync ##3 !cmd_qual);
    c_dev_x2: cover property (sync ##7 dev_d_oe);
    c_cpu_x2: cover property (sync ##7 cpu_d_oe);
endmodule

// >>> test/nibble_cpu_memory_io_interface_test.sv
/*
 * Bench joining the processor end and interface end; runs a table of
 * instructions and checks every state of every cycle.
 * Assumes one enabled clock per state, so ce_i is held high.
 */
module nibble_cpu_memory_io_interface_test
    import nmio_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed
    {
        logic [7:0] ins;
        logic fc;
        logic [11:0] pc;
        logic [3:0] acc;
        logic [7:0] src;
        logic [3:0] pin;
        logic clr;
    } nmio_op_t;

    logic clk_sys_i = 1'b0;
    logic reset_i;
    logic ce_i;
    logic half_sel_clr_i;
    logic [11:0] pc_i;
    logic fetch_cmd_i;
    logic [3:0] acc_i;
    logic [7:0] src_addr_i;
    logic [3:0] upper_nibble_in_i;
    logic [3:0] lower_nibble_in_i;
    logic [3:0] port_nibble_pins_i;
    logic [7:0] instr_o;
    logic instr_valid_o;
    logic [3:0] rd_data_o;
    logic rd_valid_o;
    logic [7:0] mem_addr_out_o;
    logic [3:0] bank_select_out_o;
    logic progmem_access_strobe_n_o;
    logic half_sel_o;
    logic [3:0] port_nibble_pins_o;
    logic port_nibble_pins_oe_o;
    logic port_rd_n_o;
    logic port_wr_n_o;
    nmio_op_t ops [0:11];
    logic hs = 1'b0;
    logic [7:0] sel_q = 8'h00;
    int num_errors = 0;
    int cmp_count = 0;
    int n;
    int k;

    // One system clock stands in for the two clock phases
    always #2.5 clk_sys_i = ~clk_sys_i;

    nmio_if link_if ();

    nmio_cpu nmio_cpu_inst
    (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .ce_i(ce_i),
        .link(link_if),
        .pc_i(pc_i),
        .fetch_cmd_i(fetch_cmd_i),
        .acc_i(acc_i),
        .src_addr_i(src_addr_i),
        .instr_o(instr_o),
        .instr_valid_o(instr_valid_o),
        .rd_data_o(rd_data_o),
        .rd_valid_o(rd_valid_o)
    );

    nmio_dev nmio_dev_inst
    (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .ce_i(ce_i),
        .half_sel_clr_i(half_sel_clr_i),
        .link(link_if),
        .upper_nibble_in_i(upper_nibble_in_i),
        .lower_nibble_in_i(lower_nibble_in_i),
        .mem_addr_out_o(mem_addr_out_o),
        .bank_select_out_o(bank_select_out_o),
        .progmem_access_strobe_n_o(progmem_access_strobe_n_o),
        .half_sel_o(half_sel_o),
        .port_nibble_pins_i(port_nibble_pins_i),
        .port_nibble_pins_o(port_nibble_pins_o),
        .port_nibble_pins_oe_o(port_nibble_pins_oe_o),
        .port_rd_n_o(port_rd_n_o),
        .port_wr_n_o(port_wr_n_o)
    );

    nmio_monitor nmio_monitor_inst
    (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .cpu_d_oe(link_if.cpu_d_oe),
        .dev_d_oe(link_if.dev_d_oe),
        .sync(link_if.sync),
        .cmd_qual(link_if.cmd_qual)
    );

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch at %0t: op %0d state %0d got %h expected %h", $time, n, k, got, exp);
        end
    endtask

    // Inputs for the next cycle go out in X2, after this cycle's captures
    task automatic drive(input int i);
        pc_i <= ops[i].pc;
        fetch_cmd_i <= ops[i].fc;
        acc_i <= ops[i].acc;
        src_addr_i <= ops[i].src;
        upper_nibble_in_i <= ops[i].ins[7:4];
        lower_nibble_in_i <= ops[i].ins[3:0];
        port_nibble_pins_i <= ops[i].pin;
    endtask

    task automatic check(input nmio_op_t o);
        logic sel;
        logic rd;
        logic wr;
        logic pm;
        logic [3:0] rv;
        logic [3:0] bus;
        bus = link_if.cpu_nibble_bus;
        sel = o.fc && o.ins[7:4] == 4'h2 && o.ins[0];
        rd = o.fc && (o.ins == 8'hea || o.ins == 8'he9);
        wr = o.fc && (o.ins == 8'he2 || o.ins == 8'he3);
        pm = o.fc && (o.ins == 8'he9 || o.ins == 8'he3);
        rv = o.ins != 8'he9 ? o.pin : (hs ? o.ins[7:4] : o.ins[3:0]);
        chk(port_rd_n_o, !(rd && k >= 5));
        chk(port_wr_n_o, !(wr && k >= 5));
        chk(progmem_access_strobe_n_o, !(pm && k >= 5));
        chk(half_sel_o, hs);
        chk(port_nibble_pins_oe_o, wr && k == 7);
        if (k == 1) chk(mem_addr_out_o[3:0], o.pc[3:0]);
        if (k >= 2 && k <= 4) chk(mem_addr_out_o, o.pc[7:0]);
        if (k == 3 || k == 4) chk(bank_select_out_o, o.pc[11:8]);
        if (k == 3) chk(bus, o.fc ? o.ins[7:4] : 4'hf);
        if (k == 4) chk(bus, o.fc ? o.ins[3:0] : 4'hf);
        // The processor end flags every fetch slot, answered or not
        if (k == 5) chk(instr_valid_o, 1'b1);
        if (k == 5 && o.fc) chk(instr_o, o.ins);
        if (k >= 6) chk(mem_addr_out_o, sel_q);
        if (k >= 6) chk(bank_select_out_o, pm ? 4'hf : sel_q[7:4]);
        if (k == 6 && (sel || rd || wr)) chk(bus, sel ? o.src[7:4] : rd ? rv : o.acc);
        if (k == 7 && sel) chk(bus, o.src[3:0]);
        if (k == 7 && wr) chk(port_nibble_pins_o, o.acc);
        if (k == 7) chk(rd_valid_o, rd);
        if (k == 7 && rd) chk(rd_data_o, rv);
    endtask

    // ----------------------------------------------------------------
    // Sequence
    // ----------------------------------------------------------------
    initial
    begin
        repeat (2000) @(posedge clk_sys_i);
        num_errors++;
        $display("mismatch at %0t: run hung", $time);
        finish_test();
    end

    initial
    begin
        reset_i = 1'b1;
        ce_i = 1'b1;
        half_sel_clr_i = 1'b0;
        // First cycle runs on ops[0] operands, captured when the processor end leaves its reset X3 state
        ops[0] = '{8'h21, 1'b1, 12'h000, 4'h0, 8'h00, 4'h3, 1'b0};
        ops[1] = '{8'he2, 1'b1, 12'hfff, 4'h6, 8'h00, 4'h3, 1'b0};
        ops[2] = '{8'hea, 1'b1, 12'h5a3, 4'h0, 8'h00, 4'hb, 1'b0};
        ops[3] = '{8'he3, 1'b1, 12'h5a4, 4'h9, 8'h00, 4'h0, 1'b0};
        ops[4] = '{8'he9, 1'b1, 12'h5a5, 4'h0, 8'h00, 4'h0, 1'b0};
        ops[5] = '{8'he2, 1'b0, 12'h123, 4'h7, 8'h00, 4'h0, 1'b0};
        ops[6] = '{8'h20, 1'b1, 12'h124, 4'h0, 8'h77, 4'h0, 1'b0};
        ops[7] = '{8'h23, 1'b1, 12'h125, 4'h0, 8'h5c, 4'h0, 1'b0};
        ops[8] = '{8'he3, 1'b1, 12'h126, 4'hc, 8'h00, 4'h0, 1'b0};
        ops[9] = '{8'he9, 1'b1, 12'h127, 4'h0, 8'h00, 4'h0, 1'b1};
        ops[10] = '{8'hea, 1'b1, 12'h128, 4'h0, 8'h00, 4'h4, 1'b0};
        ops[11] = '{8'h00, 1'b0, 12'h000, 4'h0, 8'h00, 4'h0, 1'b0};
        drive(0);
        repeat (6) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        for (n = 0; n < 11; n++)
        begin
            for (k = 0; k < 8; k++)
            begin
                @(posedge clk_sys_i);
                if (k == 0) half_sel_clr_i <= ops[n].clr;
                if (k == 1) half_sel_clr_i <= 1'b0;
                if (k == 6) drive(n + 1);
                @(negedge clk_sys_i);
                if (k == 1 && ops[n].clr) hs = 1'b0;
                check(ops[n]);
            end
            if (ops[n].fc && (ops[n].ins == 8'he3 || ops[n].ins == 8'he9)) hs = ~hs;
            if (ops[n].fc && ops[n].ins[7:4] == 4'h2 && ops[n].ins[0]) sel_q = ops[n].src;
            $display("op %0d done", n);
        end
        finish_test();
    end
endmodule
